// file: shared/spc_defines.svh
// Register map, field positions, reset values and frame counts of the serial port
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define SPC_OFS_CTRL2 5'h00
`define SPC_OFS_CTRL1 5'h04
`define SPC_OFS_BAUD 5'h08
`define SPC_OFS_STATUS 5'h0c
`define SPC_OFS_DATA 5'h10
`define SPC_OFS_CTRL3 5'h14
`define SPC_B_TX_EMPTY_IRQ_EN 7
`define SPC_B_TX_DONE_IRQ_EN 6
`define SPC_B_RX_FULL_IRQ_EN 5
`define SPC_B_IDLE_LINE_IRQ_EN 4
`define SPC_B_TRANSMITTER_ON 3
`define SPC_B_RECEIVER_ON 2
`define SPC_B_RX_STANDBY 1
`define SPC_B_SEND_BREAK 0
`define SPC_B_LOOP_SELECT 7
`define SPC_B_RX_SOURCE_SELECT 5
`define SPC_B_NINE_BIT 4
`define SPC_B_WAKE_ADDR_MARK 3
`define SPC_B_LONG_BREAK_SELECT 0
`define SPC_B_SINGLE_WIRE_DIRECTION 1
`define SPC_CTRL2_RST 8'h00
`define SPC_CTRL1_RST 8'h00
`define SPC_CTRL3_RST 2'h0
`define SPC_BAUD_RST 13'h0004
`define SPC_LEN_CHAR8 4'ha
`define SPC_LEN_CHAR9 4'hb
`define SPC_LEN_BRK8 4'hd
`define SPC_LEN_BRK9 4'he
`define SPC_OS_LAST 4'hf
`define SPC_OS_MID 4'h7
`endif

// file: shared/spc_pkg.sv
// Types shared by the serial port modules
package spc_pkg;
	typedef enum logic [1:0] {SPC_FR_DATA = 2'h0, SPC_FR_IDLE = 2'h1, SPC_FR_BREAK = 2'h2} spc_frame_t;
	typedef enum logic [1:0] {SPC_TX_IDLE = 2'b01, SPC_TX_SHIFT = 2'b10} spc_tx_state_t;
	typedef enum logic [2:0] {SPC_RX_IDLE = 3'b001, SPC_RX_START = 3'b010,
		SPC_RX_DATA = 3'b100} spc_rx_state_t;
endpackage

// file: shared/spc_tx_if.sv
// Link between transmit control and the transmit shifter
interface spc_tx_if;
	import spc_pkg::*;
	logic bit_tick;
	logic start;
	spc_frame_t kind;
	logic [8:0] data;
	logic nine_bit;
	logic long_brk;
	logic busy;
	logic line;
	modport ctl (output bit_tick, output start, output kind, output data, output nine_bit,
		output long_brk, input busy, input line);
	modport shf (input bit_tick, input start, input kind, input data, input nine_bit,
		input long_brk, output busy, output line);
endinterface

// file: hdl/spc_shifter.sv
// Transmit shifter: data, idle and break characters
`include "spc_defines.svh"
module spc_shifter (
	input wire logic mclk,
	input wire logic nrst,
	spc_tx_if.shf tx
);
	import spc_pkg::*;
	spc_tx_state_t st_q;
	logic [13:0] sh_q;
	logic [3:0] cnt_q;
	logic line_q;
	wire [3:0] char_len = tx.nine_bit ? `SPC_LEN_CHAR9 : `SPC_LEN_CHAR8;
	wire [3:0] brk_len = tx.long_brk ? (tx.nine_bit ? `SPC_LEN_BRK9 : `SPC_LEN_BRK8)
		: char_len;
	// Start, data LSB first, optional ninth bit, stop; spare top bits idle high
	wire [13:0] data_frame = tx.nine_bit ? {4'hf, tx.data[8], tx.data[7:0], 1'b0}
		: {5'h1f, tx.data[7:0], 1'b0};
	wire [13:0] frame = (tx.kind == SPC_FR_DATA) ? data_frame
		: (tx.kind == SPC_FR_IDLE) ? 14'h3fff : 14'h0000;
	wire [3:0] len = (tx.kind == SPC_FR_BREAK) ? brk_len : char_len;
	assign tx.busy = (st_q == SPC_TX_SHIFT);
	assign tx.line = line_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q <= SPC_TX_IDLE;
			sh_q <= 14'h0000;
			cnt_q <= 4'h0;
			line_q <= 1'b1;
		end else begin
			unique case (st_q)
				SPC_TX_IDLE: begin
					if (tx.start) begin
						sh_q <= frame;
						cnt_q <= len;
						st_q <= SPC_TX_SHIFT;
					end
				end
				SPC_TX_SHIFT: begin
					if (tx.bit_tick) begin
						if (cnt_q == 4'h0) begin
							line_q <= 1'b1;
							st_q <= SPC_TX_IDLE;
						end else begin
							line_q <= sh_q[0];
							sh_q <= {1'b1, sh_q[13:1]};
							cnt_q <= cnt_q - 4'h1;
						end
					end
				end
			endcase
		end
	end
endmodule // spc_shifter

// file: hdl/spc_serial_control_two.sv
// Serial port with its second control register on an Avalon-MM slave
//
// Contract
// - Bit 7 lets the transmit-buffer-empty flag raise the interrupt.
// - Bit 6 lets the transmission-complete flag raise the interrupt.
// - Bit 5 lets the receive-full flag raise the interrupt.
// - Bit 4 lets the idle-line flag raise the interrupt.
// - Bit 3 turns the transmitter on and claims the transmit pin.
// - In single-wire mode a direction bit decides drive or receive.
// - Transmitter off then on while busy queues one idle character.
// - Transmitter keeps the pin until pending data, idle, break are sent.
// - Bit 2 turns the receiver on; off releases the receive pin.
// - Loop mode releases the receive pin even with receiver on.
// - Bit 1 set puts the receiver in standby awaiting wakeup.
// - Wakeup method picks idle line or address mark wakeup.
// - Software sets standby; hardware clears it on wakeup.
// - Send break set then cleared queues one break character.
// - Held send break keeps queuing breaks of 10/11 or 13/14 bits.
// - A second break may be queued before software clears the bit.
// - The control register is readable and writable at any time.
// - Loop mode feeds transmitter to receiver; source bit picks single wire.
// - Characters are start, 8 or 9 data bits LSB first, stop.
// - An idle character is 10 or 11 bit times high.
`include "spc_defines.svh"
module spc_serial_control_two (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic txd_in,
	output logic txd_out,
	output logic txd_oe_n,
	input wire logic rxd_in,
	output logic rx_pin_owned,
	output logic irq
);
	import spc_pkg::*;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
		hit = (a == ofs);
	endfunction

	spc_tx_if txi ();
	spc_shifter u_shifter (
		.mclk(mclk),
		.nrst(nrst),
		.tx(txi)
	);

	logic wait_q;
	logic [31:0] rdata_q;
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl1_q;
	logic [1:0] ctrl3_q;
	logic [12:0] baud_q;
	logic [12:0] div_q;
	logic [3:0] os_q;
	logic [8:0] txbuf_q;
	logic tx_buffer_empty_flag_q;
	logic tc_q;
	logic idle_pend_q;
	logic brk_pend_q;
	logic start_q;
	spc_frame_t kind_q;
	logic [8:0] txdat_q;
	logic txd_out_q;
	logic txd_oe_n_q;
	logic rx_own_q;
	logic irq_q;
	logic [2:0] txs_q;
	logic [2:0] rxs_q;
	logic txf_q;
	logic rxf_q;
	spc_rx_state_t rst_q;
	logic [3:0] rph_q;
	logic [3:0] rbit_q;
	logic [8:0] rsh_q;
	logic [8:0] rxbuf_q;
	logic rx_full_flag_q;
	logic idle_q;
	logic idle_arm_q;
	logic [7:0] icnt_q;

	// Bus decode; every access is answered one cycle after it is seen
	wire req = avs_read | avs_write;
	wire acc = req & !wait_q;
	wire wr = acc & avs_write;
	wire rd = acc & avs_read;
	wire wr_c2 = wr & hit(avs_address, `SPC_OFS_CTRL2);
	wire wr_c1 = wr & hit(avs_address, `SPC_OFS_CTRL1);
	wire wr_c3 = wr & hit(avs_address, `SPC_OFS_CTRL3);
	wire wr_bd = wr & hit(avs_address, `SPC_OFS_BAUD);
	wire wr_dat = wr & hit(avs_address, `SPC_OFS_DATA);
	wire rd_dat = rd & hit(avs_address, `SPC_OFS_DATA);
	wire [7:0] wd = avs_writedata[7:0];

	wire te = ctrl2_q[`SPC_B_TRANSMITTER_ON];
	wire re = ctrl2_q[`SPC_B_RECEIVER_ON];
	wire standby = ctrl2_q[`SPC_B_RX_STANDBY];
	wire send_break = ctrl2_q[`SPC_B_SEND_BREAK];
	wire loop = ctrl1_q[`SPC_B_LOOP_SELECT];
	wire rx_source_select = ctrl1_q[`SPC_B_RX_SOURCE_SELECT];
	wire nine = ctrl1_q[`SPC_B_NINE_BIT];
	wire wake_am = ctrl1_q[`SPC_B_WAKE_ADDR_MARK];
	wire single_wire = loop & rx_source_select;
	wire [3:0] flags = {tx_buffer_empty_flag_q, tc_q, rx_full_flag_q, idle_q};

	wire [7:0] status = {flags, 4'h0};
	wire [31:0] rd_mux = hit(avs_address, `SPC_OFS_CTRL2) ? {24'h00_0000, ctrl2_q}
		: hit(avs_address, `SPC_OFS_CTRL1) ? {24'h00_0000, ctrl1_q}
		: hit(avs_address, `SPC_OFS_CTRL3) ? {30'h0000_0000, ctrl3_q}
		: hit(avs_address, `SPC_OFS_BAUD) ? {19'h0_0000, baud_q}
		: hit(avs_address, `SPC_OFS_STATUS) ? {24'h00_0000, status}
		: hit(avs_address, `SPC_OFS_DATA) ? {23'h00_0000, rxbuf_q}
		: 32'h0000_0000;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= !(req & wait_q);
			if (req & wait_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// Baud divider, 16 ticks a bit; a new divisor restarts it, else the count could run to wrap
	wire os_tick = (baud_q != 13'h0000) && (div_q == baud_q - 13'h0001);
	wire bit_tick = os_tick && (os_q == `SPC_OS_LAST);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 13'h0000;
			os_q <= 4'h0;
		end else if (os_tick || wr_bd || baud_q == 13'h0000) begin
			div_q <= 13'h0000;
			os_q <= (os_tick && !wr_bd) ? os_q + 4'h1 : 4'h0;
		end else begin
			div_q <= div_q + 13'h0001;
		end
	end

	// Transmit queue: break before idle before data
	wire te_rise = wr_c2 & !te & wd[`SPC_B_TRANSMITTER_ON];
	wire sbk_rise = wr_c2 & !send_break & wd[`SPC_B_SEND_BREAK];
	wire shf_free = !txi.busy & !start_q;
	wire ld_brk = shf_free & brk_pend_q;
	wire ld_idle = shf_free & !brk_pend_q & idle_pend_q;
	wire ld_data = shf_free & !brk_pend_q & !idle_pend_q & !tx_buffer_empty_flag_q & !wr_dat;
	wire pending = brk_pend_q | idle_pend_q | !tx_buffer_empty_flag_q;
	wire tx_owned = te | txi.busy | start_q | pending;
	wire sw_drive = !single_wire | ctrl3_q[`SPC_B_SINGLE_WIRE_DIRECTION];

	assign txi.bit_tick = bit_tick;
	assign txi.start = start_q;
	assign txi.kind = kind_q;
	assign txi.data = txdat_q;
	assign txi.nine_bit = nine;
	assign txi.long_brk = ctrl3_q[`SPC_B_LONG_BREAK_SELECT];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tx_buffer_empty_flag_q <= 1'b1;
			tc_q <= 1'b1;
			txbuf_q <= 9'h000;
			idle_pend_q <= 1'b0;
			brk_pend_q <= 1'b0;
			start_q <= 1'b0;
			kind_q <= SPC_FR_DATA;
			txdat_q <= 9'h000;
		end else begin
			start_q <= ld_brk | ld_idle | ld_data;
			if (wr_dat) begin
				txbuf_q <= avs_writedata[8:0];
				tx_buffer_empty_flag_q <= 1'b0;
			end else if (ld_data) begin
				tx_buffer_empty_flag_q <= 1'b1;
			end
			// A new request arriving as a queued one is taken keeps the queue set
			idle_pend_q <= te_rise | (idle_pend_q & !ld_idle);
			brk_pend_q <= sbk_rise | (ld_brk & send_break) | (brk_pend_q & !ld_brk);
			tc_q <= tx_buffer_empty_flag_q & !wr_dat & !te_rise & !sbk_rise & shf_free & !txi.busy
				& !idle_pend_q & !brk_pend_q;
			if (ld_brk) begin
				kind_q <= SPC_FR_BREAK;
			end else if (ld_idle) begin
				kind_q <= SPC_FR_IDLE;
			end else if (ld_data) begin
				kind_q <= SPC_FR_DATA;
				txdat_q <= txbuf_q;
			end
		end
	end

	// Pin inputs: three flops, a change counts once the last two agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			txs_q <= 3'h7;
			rxs_q <= 3'h7;
			txf_q <= 1'b1;
			rxf_q <= 1'b1;
		end else begin
			txs_q <= {txs_q[1:0], txd_in};
			rxs_q <= {rxs_q[1:0], rxd_in};
			if (txs_q[1] == txs_q[2]) begin
				txf_q <= txs_q[2];
			end
			if (rxs_q[1] == rxs_q[2]) begin
				rxf_q <= rxs_q[2];
			end
		end
	end

	wire rx_in = loop ? (rx_source_select ? txf_q : txi.line) : rxf_q;

	// Receiver: start validated at mid bit, bits sampled every 16 ticks
	wire [3:0] char_len = nine ? `SPC_LEN_CHAR9 : `SPC_LEN_CHAR8;
	wire [3:0] last_bit = nine ? 4'h9 : 4'h8;
	wire rx_done = os_tick & (rst_q == SPC_RX_DATA) & (rph_q == `SPC_OS_LAST)
		& (rbit_q == last_bit);
	wire wake_mark = standby & wake_am & rsh_q[8];
	wire accept = rx_done & (!standby | wake_mark);
	wire idle_hit = os_tick & (rst_q == SPC_RX_IDLE) & rx_in
		& (icnt_q == {char_len, 4'h0} - 8'h01);
	wire wake_idle = standby & !wake_am & idle_hit;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_q <= SPC_RX_IDLE;
			rph_q <= 4'h0;
			rbit_q <= 4'h0;
			rsh_q <= 9'h000;
			icnt_q <= 8'h00;
		end else if (!re) begin
			rst_q <= SPC_RX_IDLE;
			icnt_q <= 8'h00;
		end else if (os_tick) begin
			unique case (rst_q)
				SPC_RX_IDLE: begin
					rph_q <= 4'h0;
					rbit_q <= 4'h0;
					// Idle count saturates so the line is reported once per gap
					if (!rx_in) begin
						rst_q <= SPC_RX_START;
						icnt_q <= 8'h00;
					end else if (icnt_q != {char_len, 4'h0}) begin
						icnt_q <= icnt_q + 8'h01;
					end
				end
				SPC_RX_START: begin
					rph_q <= rph_q + 4'h1;
					if (rph_q == `SPC_OS_MID) begin
						rph_q <= 4'h0;
						rst_q <= rx_in ? SPC_RX_IDLE : SPC_RX_DATA;
					end
				end
				SPC_RX_DATA: begin
					rph_q <= rph_q + 4'h1;
					if (rph_q == `SPC_OS_LAST) begin
						rbit_q <= rbit_q + 4'h1;
						if (rbit_q == last_bit) begin
							rst_q <= SPC_RX_IDLE;
						end else begin
							rsh_q <= {rx_in, rsh_q[8:1]};
						end
					end
				end
			endcase
		end
	end

	// Flags: a hardware set wins over a software clear in the same cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rxbuf_q <= 9'h000;
			rx_full_flag_q <= 1'b0;
			idle_q <= 1'b0;
			idle_arm_q <= 1'b0;
		end else begin
			if (accept) begin
				rxbuf_q <= nine ? rsh_q : {1'b0, rsh_q[8:1]};
			end
			rx_full_flag_q <= accept | (rx_full_flag_q & !rd_dat);
			idle_q <= (idle_hit & idle_arm_q & !standby) | (idle_q & !rd_dat);
			idle_arm_q <= accept | (idle_arm_q & !idle_hit);
		end
	end

	// Registers; software write of standby wins over a wakeup in the same cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl2_q <= `SPC_CTRL2_RST;
			ctrl1_q <= `SPC_CTRL1_RST;
			ctrl3_q <= `SPC_CTRL3_RST;
			baud_q <= `SPC_BAUD_RST;
		end else begin
			if (wr_c2) begin
				ctrl2_q <= wd;
			end else if (wake_mark & rx_done | wake_idle) begin
				ctrl2_q[`SPC_B_RX_STANDBY] <= 1'b0;
			end
			if (wr_c1) begin
				ctrl1_q <= wd;
			end
			if (wr_c3) begin
				ctrl3_q <= wd[1:0];
			end
			if (wr_bd) begin
				baud_q <= avs_writedata[12:0];
			end
		end
	end

	// Outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			txd_out_q <= 1'b1;
			txd_oe_n_q <= 1'b1;
			rx_own_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			txd_out_q <= txi.line;
			txd_oe_n_q <= !(tx_owned & sw_drive);
			rx_own_q <= re & !loop;
			irq_q <= |(flags & ctrl2_q[7:4]);
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign txd_out = txd_out_q;
	assign txd_oe_n = txd_oe_n_q;
	assign rx_pin_owned = rx_own_q;
	assign irq = irq_q;
endmodule // spc_serial_control_two

// file: verif/spc_sct_asserts.sv
// Assertions on the serial port top-level ports
`include "spc_defines.svh"
module spc_sct_asserts (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic txd_oe_n,
	input wire logic rx_pin_owned,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] c2_q;
	logic [7:0] c1_q;
	wire logic done = (avs_read || avs_write) && !avs_waitrequest;
	wire logic rd_c2 = done && avs_read && avs_address == `SPC_OFS_CTRL2;
	wire logic own_exp = c2_q[2] && !c1_q[7];
	wire logic tx_exp = c2_q[3] && !c1_q[7];
	wire logic en_any = |c2_q[7:4];
	// Shadow of the CTRL2 and CTRL1 registers, taken at the edge the write completes
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			c2_q <= 8'h00;
			c1_q <= 8'h00;
		end else if (done && avs_write) begin
			if (avs_address == `SPC_OFS_CTRL2) c2_q <= avs_writedata[7:0];
			if (avs_address == `SPC_OFS_CTRL1) c1_q <= avs_writedata[7:0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	chk_one_wait: assert property (s_req |=> s_ans)
		else $error("bus answer not after one wait");
	chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("waitrequest low without request");
	chk_ctrl_readback: assert property (rd_c2 |-> avs_readdata[31:8] == 24'h00_0000
		&& {avs_readdata[7:2], avs_readdata[0]} == {c2_q[7:2], c2_q[0]})
		else $error("control register read back wrong");
	chk_upper_zero: assert property (done && avs_read |-> avs_readdata[31:13] == 19'h0_0000
		&& (avs_address == `SPC_OFS_BAUD || avs_readdata[12:9] == 4'h0))
		else $error("upper read bits not zero");
	chk_unmapped_zero: assert property (done && avs_read && avs_address > 5'h14
		|-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_rx_owned: assert property (own_exp == $past(own_exp) |-> rx_pin_owned == own_exp)
		else $error("receive pin ownership wrong");
	chk_loop_release: assert property (c1_q[7] && $past(c1_q[7]) |-> !rx_pin_owned)
		else $error("receive pin kept in loop mode");
	chk_tx_drive: assert property (tx_exp && $past(tx_exp) |-> !txd_oe_n)
		else $error("transmit pin not driven");
	chk_irq_quiet: assert property (!en_any && !$past(en_any) |-> !irq)
		else $error("interrupt with all enables off");
endmodule // spc_sct_asserts

bind spc_serial_control_two spc_sct_asserts chk_i (.mclk(mclk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .txd_oe_n(txd_oe_n),
	.rx_pin_owned(rx_pin_owned), .irq(irq));

// file: verif/spc_remote.sv
// Remote serial device facing the port's pins
module spc_remote (
	input wire logic mclk,
	input wire logic line,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT = 16;
	initial rxd = 1'b1;
	// Start bit, data LSB first, stop bit, then idle high
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			rxd <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i - 1];
			repeat (BIT) @(posedge mclk);
		end
	endtask
	task automatic hunt();
		int n;
		n = 0;
		while (line !== 1'b0 && n < 9000) begin
			@(posedge mclk);
			n++;
		end
	endtask
	// Samples mid-bit, so a cycle of skew on the line does no harm
	task automatic grab(output logic [7:0] b);
		hunt();
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge mclk);
			b[i] = line;
		end
	endtask
	task automatic brk(output int low);
		hunt();
		low = 0;
		while (line === 1'b0 && low < 400) begin
			@(posedge mclk);
			low++;
		end
	endtask
endmodule // spc_remote

// file: verif/testbench.sv
// Self-checking bench for the serial port control register
`include "spc_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, nrst, avs_read, avs_write, avs_waitrequest, txd_out, txd_oe_n, rxd_in;
	logic rx_pin_owned, irq;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0] got;
	int failures, num_checks, low;
	// A released transmit pin floats high through its pull-up
	wire logic tx_line = txd_oe_n ? 1'b1 : txd_out;
	spc_serial_control_two dut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd_in(tx_line),
		.txd_out(txd_out), .txd_oe_n(txd_oe_n), .rxd_in(rxd_in),
		.rx_pin_owned(rx_pin_owned), .irq(irq));
	spc_remote far (.mclk(mclk), .line(tx_line), .rxd(rxd_in));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			results();
		end
		@(posedge mclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk($sformatf("reg %h", a), q, e);
	endtask
	initial begin
		nrst = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0000_0000;
		failures = 0;
		num_checks = 0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		chk("pins", 32'({txd_oe_n, txd_out, rx_pin_owned, irq}), 32'h0000_000c);
		rd(`SPC_OFS_CTRL2, 32'h0000_0000);
		rd(`SPC_OFS_STATUS, 32'h0000_00c0);
		rd(5'h18, 32'h0000_0000);
		// Only buffer-empty and complete are set out of reset
		for (int i = 4; i < 8; i++) begin
			wr(`SPC_OFS_CTRL2, 32'h0000_0001 << i);
			cyc(2);
			chk("irq", 32'(irq), 32'(i > 5));
		end
		wr(`SPC_OFS_BAUD, 32'h0000_0001);
		wr(`SPC_OFS_CTRL2, 32'h0000_0034);
		cyc(2);
		chk("own irq", 32'({rx_pin_owned, irq}), 32'h0000_0002);
		far.send(8'ha5);
		cyc(240);
		rd(`SPC_OFS_STATUS, 32'h0000_00f0);
		chk("irq", 32'(irq), 32'h0000_0001);
		rd(`SPC_OFS_DATA, 32'h0000_00a5);
		cyc(2);
		chk("irq", 32'(irq), 32'h0000_0000);
		wr(`SPC_OFS_CTRL1, 32'h0000_0080);
		cyc(2);
		chk("owned", 32'(rx_pin_owned), 32'h0000_0000);
		wr(`SPC_OFS_CTRL1, 32'h0000_0008);
		wr(`SPC_OFS_CTRL2, 32'h0000_0006);
		far.send(8'h12);
		cyc(40);
		rd(`SPC_OFS_CTRL2, 32'h0000_0006);
		rd(`SPC_OFS_STATUS, 32'h0000_00c0);
		far.send(8'h92);
		cyc(40);
		rd(`SPC_OFS_CTRL2, 32'h0000_0004);
		rd(`SPC_OFS_DATA, 32'h0000_0092);
		wr(`SPC_OFS_CTRL1, 32'h0000_0000);
		// Idle-line wakeup: the quiet gap after the last character ends standby
		wr(`SPC_OFS_CTRL2, 32'h0000_0006);
		cyc(180);
		rd(`SPC_OFS_CTRL2, 32'h0000_0004);
		wr(`SPC_OFS_CTRL2, 32'h0000_0008);
		cyc(2);
		chk("oe_n", 32'(txd_oe_n), 32'h0000_0000);
		wr(`SPC_OFS_DATA, 32'h0000_00a5);
		far.grab(got);
		chk("tx byte", 32'(got), 32'h0000_00a5);
		wr(`SPC_OFS_DATA, 32'h0000_00c3);
		wr(`SPC_OFS_CTRL2, 32'h0000_0000);
		far.grab(got);
		chk("held", 32'({txd_oe_n, got}), 32'h0000_00c3);
		cyc(60);
		chk("oe_n", 32'(txd_oe_n), 32'h0000_0001);
		wr(`SPC_OFS_CTRL1, 32'h0000_00a0);
		wr(`SPC_OFS_CTRL2, 32'h0000_0008);
		cyc(2);
		chk("oe_n", 32'(txd_oe_n), 32'h0000_0001);
		wr(`SPC_OFS_CTRL3, 32'h0000_0002);
		cyc(2);
		chk("oe_n", 32'(txd_oe_n), 32'h0000_0000);
		wr(`SPC_OFS_CTRL1, 32'h0000_0000);
		// Preamble keeps the shifter busy, so only one break is queued
		for (int k = 0; k < 2; k++) begin
			wr(`SPC_OFS_CTRL3, 32'(k));
			wr(`SPC_OFS_CTRL2, 32'h0000_0000);
			wr(`SPC_OFS_CTRL2, 32'h0000_0008);
			wr(`SPC_OFS_CTRL2, 32'h0000_0009);
			wr(`SPC_OFS_CTRL2, 32'h0000_0008);
			far.brk(low);
			chk("break", 32'(low), k ? 32'h0000_00d0 : 32'h0000_00a0);
			// The idle queued by the enable toggle follows the break, so not yet complete
			rd(`SPC_OFS_STATUS, 32'h0000_0080);
		end
		// Nine-bit character through the internal loopback
		wr(`SPC_OFS_CTRL1, 32'h0000_0090);
		wr(`SPC_OFS_CTRL2, 32'h0000_000c);
		wr(`SPC_OFS_DATA, 32'h0000_01a5);
		cyc(600);
		rd(`SPC_OFS_DATA, 32'h0000_01a5);
		results();
	end
endmodule // testbench
